//--- pkg/wdrt_defines.svh
// constants for the watchdog reset timer: addresses, reset values, timing
`ifndef WDRT_DEFINES_SVH
`define WDRT_DEFINES_SVH

// special function addresses
`define WDRT_ADDR_KEY       8'hae
`define WDRT_ADDR_RELOAD    8'ha6

// key value that holds the watchdog off, also its reset value
`define WDRT_KEY_DISABLE    8'h55

// counter layout
`define WDRT_CNT_W          24
`define WDRT_CNT_RESET      24'h000000
`define WDRT_CNT_ONES       24'hffffff
`define WDRT_LOW_CLEAR      16'h0000

// default machine cycle length in core clock periods
`define WDRT_MC_BASE        4'h4

`endif

//--- pkg/wdrt_pkg.sv
// types shared by the watchdog reset timer files
package wdrt_pkg;

	typedef logic [7:0]  wdrt_byte_t;
	typedef logic [23:0] wdrt_count_t;

	// watchdog run state, gray along off -> run -> fire; the step fire -> off flips both bits
	typedef enum logic [1:0]
	{
		wdrt_off  = 2'b00,
		wdrt_run  = 2'b01,
		wdrt_fire = 2'b11
	} wdrt_state_e;

endpackage

//--- core/wdrt_mcycle.sv
// machine cycle strobe generator: counts core clocks, stretches on waits and stalls
`timescale 1ns/100ps
`default_nettype none
`include "wdrt_defines.svh"

module wdrt_mcycle
	import wdrt_pkg::*;
(
	input  wire logic       core_clk,      // core clock
	input  wire logic       rstn,          // async reset, active low
	input  wire logic       mem_xfer,      // memory transfer this machine cycle
	input  wire logic [3:0] bus_wait_len,  // configured bus cycle length in clocks
	input  wire logic       stall,         // prefetch queue or branch cache stall
	output logic            mc_strobe      // one-cycle pulse per machine cycle
);

	logic [3:0] phase;
	logic [3:0] next_phase;
	logic       next_mc_strobe;
	logic [3:0] target;

	// =====================================================================
	// phase counter
	// =====================================================================
	// length is four, or the bus length when longer during a transfer
	always_comb
	begin
		target = `WDRT_MC_BASE;
		if (mem_xfer && (bus_wait_len > `WDRT_MC_BASE))
			target = bus_wait_len;
		next_phase     = phase;
		next_mc_strobe = 1'b0;
		if (!stall)
		begin
			if (phase + 4'h1 >= target)
			begin
				next_phase     = 4'h0;
				next_mc_strobe = 1'b1;
			end
			else
				next_phase = phase + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			phase     <= 4'h0;
			mc_strobe <= 1'b0;
		end
		else
		begin
			phase     <= next_phase;
			mc_strobe <= next_mc_strobe;
		end
	end

endmodule
`default_nettype wire

//--- core/wdrt_top.sv
// watchdog reset timer: key and reload registers, 24-bit counter, reset request
// =====================================================================
// Summary of operation
// - while enabled, every counter overflow requests a system reset
// - no counting in idle or power-down mode
// - key 55h disables; any other key enables counting from its write
// - every reset loads the key with 55h
// - counter is 24 bits, counts up, cleared to zero by reset
// - enabled counter advances by one per machine cycle
// - overflow past all ones fires reset and restores key 55h
// - reload write sets upper byte, clears lower sixteen bits
// - machine cycle is four clocks, longer with longer bus cycles
// - prefetch or branch cache stall stretches the machine cycle
// - key at special address aeh, reload at a6h, both written
// =====================================================================
`timescale 1ns/100ps
`default_nettype none
`include "wdrt_defines.svh"

module wdrt_top
	import wdrt_pkg::*;
(
	input  wire logic       core_clk,      // core clock, 200 MHz
	input  wire logic       rstn,          // async system reset, active low
	input  wire logic       sfr_wr,        // special function register write strobe
	input  wire logic [7:0] sfr_addr,      // special function register address
	input  wire logic [7:0] sfr_wdata,     // write data
	input  wire logic       idle_mode,     // core in idle mode
	input  wire logic       powerdown_mode,// core in power-down mode
	input  wire logic       mem_xfer,      // memory transfer in this machine cycle
	input  wire logic [3:0] bus_wait_config,// bus cycle length in clocks
	input  wire logic       prefetch_stall,// prefetch queue or branch cache stall
	output logic            wd_reset_req,  // one-cycle system reset request
	output logic            wd_enabled,    // key not 55h
	output logic [23:0]     wd_count       // counter value
);

	wdrt_byte_t  watchdog_key;
	wdrt_byte_t  next_watchdog_key;
	wdrt_count_t watchdog_counter;
	wdrt_count_t next_watchdog_counter;
	wdrt_state_e state;
	wdrt_state_e next_state;
	logic        next_reset_req;
	logic        mc_strobe;
	logic        key_wr;
	logic        reload_wr;
	logic        enabled;
	logic        next_enabled;

	// decode of the two write-only addresses
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
		addr_hit = (a == target);
	endfunction

	// =====================================================================
	// machine cycle timing
	// =====================================================================
	// strobe from core
	wdrt_mcycle u_mcycle
	(
		.core_clk     (core_clk),
		.rstn         (rstn),
		.mem_xfer     (mem_xfer),
		.bus_wait_len (bus_wait_config),
		.stall        (prefetch_stall),
		.mc_strobe    (mc_strobe)
	);

	// =====================================================================
	// register writes and counter
	// =====================================================================
	// register address decode
	assign key_wr    = sfr_wr && addr_hit(sfr_addr, `WDRT_ADDR_KEY);
	assign reload_wr = sfr_wr && addr_hit(sfr_addr, `WDRT_ADDR_RELOAD);
	assign enabled   = (watchdog_key != `WDRT_KEY_DISABLE);

	// next key, counter and state; reload beats a same-cycle increment
	always_comb
	begin
		next_watchdog_key     = watchdog_key;
		next_watchdog_counter = watchdog_counter;
		next_state            = state;
		next_reset_req        = 1'b0;
		if (key_wr)
			next_watchdog_key = sfr_wdata;
		case (state)
			wdrt_off:
			begin
				if (enabled)
					next_state = wdrt_run;
			end
			wdrt_run:
			begin
				if (!enabled)
					next_state = wdrt_off;
				else if (mc_strobe && !idle_mode && !powerdown_mode && !reload_wr)
				begin
					if (watchdog_counter == `WDRT_CNT_ONES)
					begin
						next_state        = wdrt_fire;
						next_watchdog_key = `WDRT_KEY_DISABLE;
						next_reset_req    = 1'b1;
					end
					next_watchdog_counter = watchdog_counter + 24'h000001;
				end
			end
			wdrt_fire:
			begin
				next_state = wdrt_off;
			end
			default:
			begin
				next_state = wdrt_off;
			end
		endcase
		if (reload_wr)
			next_watchdog_counter = {sfr_wdata, `WDRT_LOW_CLEAR};
		// enable flag follows the key that will be stored
		next_enabled = (next_watchdog_key != `WDRT_KEY_DISABLE);
	end

	// only registers; key and counter reset with every system reset
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			watchdog_key     <= `WDRT_KEY_DISABLE;
			watchdog_counter <= `WDRT_CNT_RESET;
			state            <= wdrt_off;
			wd_reset_req     <= 1'b0;
			wd_enabled       <= 1'b0;
			wd_count         <= `WDRT_CNT_RESET;
		end
		else
		begin
			watchdog_key     <= next_watchdog_key;
			watchdog_counter <= next_watchdog_counter;
			state            <= next_state;
			wd_reset_req     <= next_reset_req;
			wd_enabled       <= next_enabled;
			wd_count         <= next_watchdog_counter;
		end
	end

endmodule
`default_nettype wire

//--- bench/wdrt_core_model.sv
// processor core model: issues register writes
`timescale 1ns/100ps
`default_nettype none
module wdrt_core_model
(
	input  wire logic       core_clk,  // clock
	output logic            sfr_wr,    // write strobe
	output logic [7:0]      sfr_addr,  // address
	output logic [7:0]      sfr_wdata  // data
);
	initial
	begin
		{sfr_wr, sfr_addr, sfr_wdata} = 17'h00000;
	end
	// one-cycle write, then strobe drops and address and data lines are driven inverted
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
		@(posedge core_clk);
		#1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

//--- bench/wdrt_top_chk.sv
// port assertions for the watchdog reset timer
`timescale 1ns/100ps
`default_nettype none
module wdrt_top_chk
	import wdrt_pkg::*;
(
	input wire logic        core_clk,       // clock
	input wire logic        rstn,           // reset
	input wire logic        sfr_wr,         // strobe
	input wire logic [7:0]  sfr_addr,       // address
	input wire logic [7:0]  sfr_wdata,      // data
	input wire logic        idle_mode,      // idle
	input wire logic        powerdown_mode, // power-down
	input wire logic        wd_reset_req,   // request
	input wire logic        wd_enabled,     // enabled
	input wire logic [23:0] wd_count        // counter
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// a count change that no write explains
	sequence s_inc;
		$changed(wd_count) && !$past(sfr_wr);
	endsequence
	sequence s_wrap;
		s_inc ##0 $past(wd_count) == 24'hffffff;
	endsequence
	a_reload_load: assert property (sfr_wr && sfr_addr == 8'ha6 |=> wd_count == {$past(sfr_wdata), 16'h0000})
		else $error("reload value wrong");
	a_key_off: assert property (sfr_wr && sfr_addr == 8'hae && sfr_wdata == 8'h55 |=> !wd_enabled)
		else $error("key did not disable");
	a_key_on: assert property (sfr_wr && sfr_addr == 8'hae && sfr_wdata != 8'h55
		&& wd_count != 24'hffffff |=> wd_enabled)
		else $error("key did not enable");
	a_idle_hold: assert property ((idle_mode || powerdown_mode) && !sfr_wr |=> $stable(wd_count))
		else $error("counted while paused");
	a_step_one: assert property (s_inc ##0 $past(wd_count) != 24'hffffff |-> wd_count == $past(wd_count) + 24'h1)
		else $error("step not one");
	a_wrap_fire: assert property (s_wrap |-> wd_count == 24'h0 && wd_reset_req && !wd_enabled)
		else $error("overflow without reset");
	// a request pulse only ever follows the all-ones count
	a_req_at_wrap: assert property (wd_reset_req |-> $past(wd_count) == 24'hffffff && wd_count == 24'h0)
		else $error("request without overflow");
	// stretches only lengthen the four-clock cycle
	a_inc_gap: assert property (s_inc |=> (!$changed(wd_count) || $past(sfr_wr)) [*3])
		else $error("increments too close");
	a_off_frozen: assert property (!wd_enabled && !sfr_wr |=> $stable(wd_count))
		else $error("counted while off");
endmodule
bind wdrt_top wdrt_top_chk u_chk (.core_clk, .rstn, .sfr_wr, .sfr_addr, .sfr_wdata, .idle_mode,
	.powerdown_mode, .wd_reset_req, .wd_enabled, .wd_count);
`default_nettype wire

//--- bench/wdrt_top_test.sv
// self-checking bench for the watchdog reset timer
`timescale 1ns/100ps
`default_nettype none
module wdrt_top_test;
	logic        core_clk, rstn, idle_mode, powerdown_mode, mem_xfer, prefetch_stall;
	logic        sfr_wr, wd_reset_req, wd_enabled;
	logic [3:0]  bus_wait_config;
	logic [7:0]  sfr_addr, sfr_wdata;
	logic [23:0] wd_count, c0;
	logic [23:0] n_req = 24'h0;
	int          fails = 0;
	int          n_compared = 0;
	wdrt_core_model u_core (.core_clk, .sfr_wr, .sfr_addr, .sfr_wdata);
	wdrt_top u_dut (.core_clk, .rstn, .sfr_wr, .sfr_addr, .sfr_wdata, .idle_mode, .powerdown_mode,
		.mem_xfer, .bus_wait_config, .prefetch_stall, .wd_reset_req, .wd_enabled, .wd_count);
	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	// request pulses, counted on the falling edge where the output has settled
	always @(negedge core_clk)
	begin
		if (rstn === 1'b1 && wd_reset_req !== 1'b0)
			n_req <= n_req + 24'h1;
	end
	task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// warm-up first so a mode change settles before counting
	task span(input logic [23:0] e);
		repeat (8) @(posedge core_clk);
		#1 c0 = wd_count;
		repeat (40) @(posedge core_clk);
		#1 chk("steps", e, wd_count - c0);
	endtask
	task t_reset;
		chk("count", 24'h0, wd_count);
		chk("enabled", 24'h0, wd_enabled);
		chk("request", 24'h0, wd_reset_req);
	endtask
	task t_keys;
		u_core.wr(8'h5a, 8'haa);
		chk("enabled", 24'h0, wd_enabled);
		u_core.wr(8'hae, 8'haa);
		chk("enabled", 24'h1, wd_enabled);
		u_core.wr(8'ha6, 8'h12);
		chk("count", 24'h120000, wd_count);
	endtask
	task t_timing;
		span(24'ha);
		{mem_xfer, bus_wait_config} = 5'h18;
		span(24'h5);
		// long bus setting without a transfer keeps four clocks
		mem_xfer = 0;
		span(24'ha);
		prefetch_stall = 1;
		span(24'h0);
		{prefetch_stall, idle_mode} = 2'h1;
		span(24'h0);
		{idle_mode, powerdown_mode} = 2'h1;
		span(24'h0);
		powerdown_mode = 0;
		u_core.wr(8'hae, 8'h55);
		chk("enabled", 24'h0, wd_enabled);
		span(24'h0);
	endtask
	// a reset in mid-run must put the key back to off and clear the count;
	// overflow itself needs over 260k clocks, too long here, so the checker guards it
	task t_rerst;
		u_core.wr(8'hae, 8'h3c);
		u_core.wr(8'ha6, 8'h34);
		chk("count", 24'h340000, wd_count);
		span(24'ha);
		rstn = 0;
		repeat (2) @(posedge core_clk);
		#1 rstn = 1;
		chk("count", 24'h0, wd_count);
		chk("enabled", 24'h0, wd_enabled);
		span(24'h0);
		chk("reset requests", 24'h0, n_req);
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#20000;
		fails++;
		give_verdict;
	end
	initial
	begin
		{rstn, idle_mode, powerdown_mode, mem_xfer, prefetch_stall} = 5'h00;
		bus_wait_config = 4'h4;
		repeat (5) @(posedge core_clk);
		#1 rstn = 1;
		t_reset;
		t_keys;
		t_timing;
		t_rerst;
		give_verdict;
	end
endmodule
`default_nettype wire
